// file: dv/io_alloc_monitor.sv
// Port checker for the allocation and inversion block.
// Assumes config reaches the block only through the write strobe.
`timescale 1ns/1ps
module io_alloc_monitor #(parameter num_terms = 7) (
  // Clock, reset, register port
  input wire ref_clk,
  input wire reset,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata,
  // Terminals and signals
  input wire [num_terms-1:0] term_in,
  input wire sig_out_1_2,
  input wire sig_out_23_24,
  input wire sig_out_25_26,
  input wire capture_input_a,
  input wire capture_input_b,
  input wire origin_switch,
  input wire out_1_2,
  input wire out_23_24,
  input wire out_25_26
);
  reg [15:0] ist, iact, pst, pact;
  function dec(input [3:0] c, input [num_terms-1:0] t);
    dec = c < 7 ? t[c] : c == 7 ? 1'b1 : c == 8 ? 1'b0 : !t[c-9];
  endfunction
  // Shadow copies of stored and active words
  always @(posedge ref_clk) begin
    if (reset) begin
      ist <= 16'h6543;
      iact <= 16'h6543;
      pst <= 16'h0000;
      pact <= 16'h0000;
    end else begin
      if (wr && addr == 16'h2511) ist <= wdata;
      if (wr && addr == 16'h2512) pst <= wdata & 16'h0111;
      if (wr && addr == 16'h2583 && wdata[0]) begin
        iact <= ist;
        pact <= pst;
      end
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_cap_a_dec: assert property (!$past(reset) |->
    capture_input_a == dec($past(iact[7:4]), $past(term_in)))
    else $error("capture a wrong");
  a_cap_b_dec: assert property (!$past(reset) |-> capture_input_b == dec($past(iact[11:8]), $past(term_in)))
    else $error("capture b wrong");
  a_origin_dec: assert property (!$past(reset) |-> origin_switch == dec($past(iact[15:12]), $past(term_in)))
    else $error("origin wrong");
  a_inv_first: assert property (!$past(reset) |-> out_1_2 == ($past(sig_out_1_2) ^ $past(pact[0])))
    else $error("out 1_2 wrong");
  a_inv_second: assert property (!$past(reset) |-> out_23_24 == ($past(sig_out_23_24) ^ $past(pact[4])))
    else $error("out 23_24 wrong");
  a_inv_third: assert property (!$past(reset) |-> out_25_26 == ($past(sig_out_25_26) ^ $past(pact[8])))
    else $error("out 25_26 wrong");
  a_pol_readback: assert property (rd && addr == 16'h2512 |=> rdata == $past(pst))
    else $error("polarity readback wrong");
  a_assign_readback: assert property (rd && addr == 16'h2511 |=> rdata == $past(ist))
    else $error("assign readback wrong");
  c_restart: cover property (wr && addr == 16'h2583 && wdata[0]);
  c_open_active: cover property (capture_input_a && $past(iact[7:4]) == 4'hf);
  c_inverted: cover property (out_25_26 && !$past(sig_out_25_26));
endmodule // io_alloc_monitor
bind io_signal_allocation_inversion io_alloc_monitor #(.num_terms(num_terms)) mon (.ref_clk(ref_clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .term_in(term_in), .sig_out_1_2(sig_out_1_2),
  .sig_out_23_24(sig_out_23_24), .sig_out_25_26(sig_out_25_26), .capture_input_a(capture_input_a),
  .capture_input_b(capture_input_b), .origin_switch(origin_switch), .out_1_2(out_1_2), .out_23_24(out_23_24),
  .out_25_26(out_25_26));

// file: dv/io_signal_allocation_inversion_tb.sv
// Bench for the allocation and inversion block.
// Assumes the switch model and the checker are compiled first.
`timescale 1ns/1ps
module io_signal_allocation_inversion_tb;
  reg ref_clk = 0, reset = 1, wr = 0, rd = 0;
  reg [15:0] addr = 0, wdata = 0;
  reg [6:0] closed = 0;
  reg [2:0] sig = 0;
  wire [15:0] rdata;
  wire [6:0] term_in;
  wire [5:0] got;
  integer err_total = 0, cmp_count = 0, cyc = 0, i;
  reg [47:0] rows [0:3];
  switch_bank sw (.closed(closed), .term_in(term_in));
  io_signal_allocation_inversion dut (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .term_in(term_in), .sig_out_1_2(sig[2]), .sig_out_23_24(sig[1]),
    .sig_out_25_26(sig[0]), .capture_input_a(got[5]), .capture_input_b(got[4]), .origin_switch(got[3]),
    .out_1_2(got[2]), .out_23_24(got[1]), .out_25_26(got[0]));
  initial forever #25 ref_clk = ~ref_clk;
  // Cycle ceiling against hangs
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 400) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input [15:0] e, input [15:0] v);
    cmp_count = cmp_count + 1;
    if (v !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH %s exp %h got %h", nm, e, v);
    end
  endtask
  task wr_reg(input [15:0] a, input [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge ref_clk);
    wr <= 0;
  endtask
  task rd_chk(input [15:0] a, input [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1;
    @(posedge ref_clk);
    rd <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Rows: assign word, polarity word, closed contacts, signals, expected
  initial begin
    rows[0] = {16'h6543, 16'h0000, 7'h10, 3'b101, 6'b100101};
    rows[1] = {16'h78f0, 16'h0111, 7'h00, 3'b000, 6'b101111};
    rows[2] = {16'h8790, 16'h0010, 7'h01, 3'b111, 6'b010101};
    rows[3] = {16'h0ff0, 16'h0100, 7'h40, 3'b000, 6'b000001};
    repeat (8) @(posedge ref_clk);
    reset <= 0;
    rd_chk(16'h2511, 16'h6543);
    rd_chk(16'h2512, 16'h0000);
    $display("test reset_values done");
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(16'h2511, rows[i][47:32]);
      wr_reg(16'h2512, rows[i][31:16]);
      wr_reg(16'h2583, 16'h0001);
      closed <= rows[i][15:9];
      sig <= rows[i][8:6];
      repeat (3) @(posedge ref_clk);
      #1 chk("functions", {10'h0, rows[i][5:0]}, {10'h0, got});
      $display("test row %0d done", i);
    end
    wr_reg(16'h2512, 16'hffff);
    rd_chk(16'h2512, 16'h0111);
    chk("no_restart", 16'h0001, {10'h0, got});
    rd_chk(16'h1234, 16'h0000);
    $display("test awkward done");
    // Mid-run reset: outputs low, then defaults back in force
    @(posedge ref_clk);
    reset <= 1;
    @(posedge ref_clk);
    reset <= 0;
    #1 chk("reset_outs", 16'h0000, {10'h0, got});
    @(posedge ref_clk);
    #1 chk("default_alloc", 16'h0008, {10'h0, got});
    rd_chk(16'h2580, 16'h6543);
    rd_chk(16'h2581, 16'h0000);
    rd_chk(16'h2582, 16'h0440);
    rd_chk(16'h2583, 16'h0000);
    $display("test mid_reset done");
    tally_and_finish;
  end
endmodule // io_signal_allocation_inversion_tb

// file: dv/switch_bank.sv
// External contacts on the connector input terminals.
// Assumes the bench sets which contacts are closed, synchronous to the clock.
`timescale 1ns/1ps
module switch_bank (
  // Contact states from the bench, high means closed
  input wire [6:0] closed,
  // Levels seen at the input terminals
  output wire [6:0] term_in
);
  // Closed contact reads high, open contact reads low
  assign term_in = closed;
endmodule // switch_bank

// file: src/alloc_decode.v
// One allocation digit decoder: picks a terminal and level, or a constant.
// Assumes terminal inputs are already synchronous to the clock.
`timescale 1ns/1ps
`include "io_alloc_defs.vh"

module alloc_decode #(
  parameter num_terms = 7
) (
  // Allocation code and terminals
  input wire [3:0] code,
  input wire [num_terms-1:0] term_in,
  // Decoded function level, high means active
  output reg active
);

  wire [3:0] off_index;

  // Terminal index for the off-level codes 9..F
  assign off_index = code - `ALLOC_OFF_FIRST;

  // Decode code: 0..6 on-level, 7 always, 8 never, 9..F off-level
  always @* begin
    if (code <= `ALLOC_ON_LAST) begin
      active = term_in[code[2:0]];
    end else if (code == `ALLOC_ALWAYS_ON) begin
      active = 1'b1;
    end else if (code == `ALLOC_ALWAYS_OFF) begin
      active = 1'b0;
    end else begin
      active = ~term_in[off_index[2:0]];
    end
  end

endmodule // alloc_decode

// file: src/io_alloc_defs.vh
// Register offsets, field positions, reset values and decode codes
// for the connector signal allocation and output inversion block.
// Assumes a 16-bit register address on a plain strobe port.
`ifndef IO_ALLOC_DEFS_VH
`define IO_ALLOC_DEFS_VH

// Register offsets
`define ADDR_INPUT_FUNCTION_ASSIGN 16'h2511
`define ADDR_OUTPUT_POLARITY_CONFIG 16'h2512
`define ADDR_ACTIVE_INPUT_ASSIGN 16'h2580
`define ADDR_ACTIVE_POLARITY 16'h2581
`define ADDR_IO_STATUS 16'h2582
`define ADDR_CONTROL 16'h2583

// Reset values
`define RST_INPUT_FUNCTION_ASSIGN 16'h6543
`define RST_OUTPUT_POLARITY_CONFIG 16'h0000

// Digit positions in the input selection word
`define DIG_CAPTURE_A_LSB 4
`define DIG_CAPTURE_B_LSB 8
`define DIG_ORIGIN_LSB 12

// Digit positions in the polarity word (bit 0 of each digit)
`define POL_OUT_1_2_BIT 0
`define POL_OUT_23_24_BIT 4
`define POL_OUT_25_26_BIT 8

// Allocation codes
`define ALLOC_ON_LAST 4'h6
`define ALLOC_ALWAYS_ON 4'h7
`define ALLOC_ALWAYS_OFF 4'h8
`define ALLOC_OFF_FIRST 4'h9

// Control register bit: restart request
`define CTRL_RESTART_BIT 0

`endif

// file: src/io_signal_allocation_inversion.v
// Connector input allocation to capture and origin functions, and
// polarity inversion of three output terminal pairs.
// Assumes one 20 MHz clock, synchronous inputs and a strobe register port.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "io_alloc_defs.vh"

//
// Function
// [R01] The first capture input is allocated by bits 7:4 of the input selection word.
// [R02] Code F makes the first capture input active while terminal 12 is open.
// [R03] The second capture input takes codes 0 to F in bits 11:8, decoded like the first.
// [R04] The origin switch input is allocated by bits 15:12 with the same decoding.
// [R05] Polarity bit 0 inverts the output on terminals 1 and 2 when set.
// [R06] Polarity digit 1 inverts the output on terminals 23 and 24 when set.
// [R07] Polarity digit 2 inverts the output on terminals 25 and 26 when set.
// [R08] The polarity word holds 0 or 1 per low digit, resets to zero, top digit reserved, used after restart.
module io_signal_allocation_inversion #(
  parameter num_terms = 7
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Register port
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  // Connector input terminals, index 6 is terminal 12, high means closed
  input wire [num_terms-1:0] term_in,
  // Internal output signals before inversion
  input wire sig_out_1_2,
  input wire sig_out_23_24,
  input wire sig_out_25_26,
  // Decoded functions, high means active
  output reg capture_input_a,
  output reg capture_input_b,
  output reg origin_switch,
  // Output terminal pairs
  output reg out_1_2,
  output reg out_23_24,
  output reg out_25_26
);

  ////////////////////////////////////////////////////////////////////////
  // Polarity and status word helpers

  // Keep bit 0 of each of the low three polarity digits
  function [2:0] pack_polarity;
    input [15:0] word;
    begin
      pack_polarity = {word[`POL_OUT_25_26_BIT], word[`POL_OUT_23_24_BIT], word[`POL_OUT_1_2_BIT]};
    end
  endfunction

  // Spread three polarity bits back into their digits, top digit zero
  function [15:0] unpack_polarity;
    input [2:0] pol;
    begin
      unpack_polarity = 16'h0000;
      unpack_polarity[`POL_OUT_1_2_BIT] = pol[0];
      unpack_polarity[`POL_OUT_23_24_BIT] = pol[1];
      unpack_polarity[`POL_OUT_25_26_BIT] = pol[2];
    end
  endfunction

  // Status word: three functions, three outputs, then the terminals
  function [15:0] status_word;
    input [5:0] levels;
    input [6:0] terms;
    begin
      status_word = {3'h0, levels, terms};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Stored and active configuration

  reg [15:0] input_function_assign;
  reg [2:0] output_polarity_config;
  reg [15:0] active_assign;
  reg [2:0] active_polarity;
  wire sel_assign;
  wire sel_polarity;
  wire sel_control;
  wire restart_req;
  wire dec_a;
  wire dec_b;
  wire dec_home;

  // Register address decode
  assign sel_assign = (addr == `ADDR_INPUT_FUNCTION_ASSIGN);
  assign sel_polarity = (addr == `ADDR_OUTPUT_POLARITY_CONFIG);
  assign sel_control = (addr == `ADDR_CONTROL);
  assign restart_req = wr && sel_control && wdata[`CTRL_RESTART_BIT];

  // Software writes the stored selection word; digit 0 kept but unused
  always @(posedge ref_clk) begin
    if (reset) begin
      input_function_assign <= `RST_INPUT_FUNCTION_ASSIGN;
    end else if (wr && sel_assign) begin
      input_function_assign <= wdata;
    end
  end

  // Software writes the stored polarity; other bits and top digit dropped
  always @(posedge ref_clk) begin
    if (reset) begin
      output_polarity_config <= pack_polarity(`RST_OUTPUT_POLARITY_CONFIG); // [R08]
    end else if (wr && sel_polarity) begin
      output_polarity_config <= pack_polarity(wdata); // [R08]
    end
  end

  // Stored values take effect only at restart, so a half-written
  // configuration never reaches the terminals
  always @(posedge ref_clk) begin
    if (reset) begin
      active_assign <= `RST_INPUT_FUNCTION_ASSIGN;
      active_polarity <= pack_polarity(`RST_OUTPUT_POLARITY_CONFIG);
    end else if (restart_req) begin
      active_assign <= input_function_assign; // [R08]
      active_polarity <= output_polarity_config; // [R08]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input allocation

  // First capture input from bits 7:4
  alloc_decode #(.num_terms(num_terms)) u_dec_a (
    .code(active_assign[`DIG_CAPTURE_A_LSB +: 4]), // [R01] [R02]
    .term_in(term_in),
    .active(dec_a)
  );

  // Second capture input from bits 11:8
  alloc_decode #(.num_terms(num_terms)) u_dec_b (
    .code(active_assign[`DIG_CAPTURE_B_LSB +: 4]), // [R03]
    .term_in(term_in),
    .active(dec_b)
  );

  // Origin switch from bits 15:12
  alloc_decode #(.num_terms(num_terms)) u_dec_home (
    .code(active_assign[`DIG_ORIGIN_LSB +: 4]), // [R04]
    .term_in(term_in),
    .active(dec_home)
  );

  // Register the decoded functions so the outputs come from flip-flops
  // and settle one cycle after the terminals
  always @(posedge ref_clk) begin
    if (reset) begin
      capture_input_a <= 1'b0;
      capture_input_b <= 1'b0;
      origin_switch <= 1'b0;
    end else begin
      capture_input_a <= dec_a; // [R01] [R02]
      capture_input_b <= dec_b; // [R03]
      origin_switch <= dec_home; // [R04]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output inversion

  reg next_out_1_2;
  reg next_out_23_24;
  reg next_out_25_26;

  // Each terminal pair flips where its active polarity bit is set
  always @* begin
    next_out_1_2 = sig_out_1_2 ^ active_polarity[0]; // [R05]
    next_out_23_24 = sig_out_23_24 ^ active_polarity[1]; // [R06]
    next_out_25_26 = sig_out_25_26 ^ active_polarity[2]; // [R07]
  end

  // Output terminal registers, low while in reset
  always @(posedge ref_clk) begin
    if (reset) begin
      out_1_2 <= 1'b0;
      out_23_24 <= 1'b0;
      out_25_26 <= 1'b0;
    end else begin
      out_1_2 <= next_out_1_2; // [R05]
      out_23_24 <= next_out_23_24; // [R06]
      out_25_26 <= next_out_25_26; // [R07]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe

  reg [15:0] next_rdata;

  // Read data chosen by address; unmapped addresses and idle cycles
  // read zero, and the control word is write-only
  always @* begin
    next_rdata = 16'h0000;
    if (rd) begin
      case (addr)
        `ADDR_INPUT_FUNCTION_ASSIGN: next_rdata = input_function_assign;
        `ADDR_OUTPUT_POLARITY_CONFIG: next_rdata = unpack_polarity(output_polarity_config); // [R08]
        `ADDR_ACTIVE_INPUT_ASSIGN: next_rdata = active_assign;
        `ADDR_ACTIVE_POLARITY: next_rdata = unpack_polarity(active_polarity);
        `ADDR_IO_STATUS: next_rdata = status_word({capture_input_a, capture_input_b, origin_switch,
                                                   out_1_2, out_23_24, out_25_26}, term_in);
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  // Read data register, so the value stands for as many cycles as the read strobe was held
  always @(posedge ref_clk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule // io_signal_allocation_inversion
